// File: ppm_pkg.sv
// Purpose: Constants for the printer port pin mapping block
// Assumes: AHB-Lite register bus, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
package ppm_pkg;
    // Register byte offsets
    localparam logic [7:0] DATA_OFS   = 8'h00; // Port data latch
    localparam logic [7:0] STATUS_OFS = 8'h04; // Printer status
    localparam logic [7:0] CTRL_OFS   = 8'h08; // Printer control
    localparam logic [7:0] MODE_OFS   = 8'h0c; // Port mode select
    // Control bit positions
    localparam int CTL_STROBE = 0; // Data latch pulse
    localparam int CTL_ALF    = 1; // Auto line feed
    localparam int CTL_INIT   = 2; // Printer initialise
    localparam int CTL_SELIN  = 3; // Printer select
    localparam int CTL_DIR    = 5; // Data lines read back from printer
    // Status bit positions
    localparam int ST_FAULT   = 3;
    localparam int ST_SELECT  = 4;
    localparam int ST_PAPER   = 5;
    localparam int ST_ACK     = 6;
    localparam int ST_BUSY    = 7;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h04; // Init released after reset
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] MODE_RST = 2'h0;  // Standard compatible mode
    localparam logic [1:0] MODE_STD = 2'h0;
endpackage : ppm_pkg

// File: ppm_reg8.sv
// Purpose: Byte register with write strobe and registered output
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Used for the data latch and control register
module ppm_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       sys_clk_in, // System clock
    input  wire logic       rst_in,     // Async reset
    input  wire logic       wr_in,      // Write strobe
    input  wire logic [7:0] d_in,       // Write data
    output logic      [7:0] q_out       // Stored value
);
    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    // Next value: load on strobe
    always_comb begin
        nxt_q = wr_in ? d_in : q_ff;
    end

    // Storage
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= RST_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_out = q_ff;
endmodule : ppm_reg8

// File: ppm_port.sv
// Purpose: Standard-mode printer port pins behind AHB-Lite registers
// Assumes: Printer pins synchronous to sys_clk_in; single word transfers
// Notes:   Zero wait states; response always OKAY
// Operation
// - Init output equals control bit 2
// - Select output is inverse of bit 3
// - Status bit 4 reads printer selected
// - Status bit 5 reads paper out
// - Status bit 7 reads inverted busy
// - Status bit 6 reads acknowledge uninverted
// - Eight bidirectional data lines carry one byte
// - Strobe output is inverse of bit 0
// - Line feed output inverse of bit 1
// - Status bit 3 reads fault uninverted
module ppm_port (
    input  wire logic        sys_clk_in,              // 25 MHz clock
    input  wire logic        rst_in,                  // Async reset
    input  wire logic        hsel,                    // AHB select
    input  wire logic [31:0] haddr,                   // AHB address
    input  wire logic [1:0]  htrans,                  // AHB transfer type
    input  wire logic        hwrite,                  // AHB direction
    input  wire logic [2:0]  hsize,                   // AHB size
    input  wire logic [31:0] hwdata,                  // AHB write data
    input  wire logic        hready,                  // AHB bus ready
    output logic      [31:0] hrdata,                  // AHB read data
    output logic             hreadyout,               // AHB slave ready
    output logic             hresp,                   // AHB response
    output logic             printer_initialise_n,    // Init output
    output logic             printer_select_out_n,    // Select output
    output logic             data_latch_pulse_n,      // Strobe output
    output logic             auto_line_feed_n,        // Line feed output
    input  wire logic        printer_selected_in,     // Printer powered
    input  wire logic        paper_out_in,            // No paper
    input  wire logic        printer_busy_in,         // Printer busy
    input  wire logic        printer_acknowledge_n,   // Acknowledge
    input  wire logic        printer_fault_n,         // Error
    input  wire logic [7:0]  port_data_in_in,         // Data lines sensed
    output logic      [7:0]  port_data_out_out,       // Data lines driven
    output logic             port_data_oe_n_out,      // Low while driving
    output logic             std_mode_out             // High in standard mode
);
    ////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    logic       wr_pend_ff;  // Write data phase pending
    logic       nxt_wr_pend;
    logic [7:0] addr_ff;     // Captured offset
    logic [7:0] nxt_addr;
    logic [1:0] mode_ff;     // Port mode
    logic [1:0] nxt_mode;
    logic [31:0] rdata_ff;   // Registered read data
    logic [31:0] nxt_rdata;
    logic [7:0] ctrl_q;      // Control register
    logic [7:0] data_q;      // Data latch
    logic [7:0] status;      // Live status byte
    logic       take;        // Valid address phase
    logic       wr_ctrl;
    logic       wr_data;

    // Valid transfer sampled while bus ready
    assign take = hsel && hready && htrans[1];

    // Zero-extend a register byte onto the read bus
    function automatic logic [31:0] rd_word(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction : rd_word

    // Status byte: live pins, low bits read zero
    // Levels are not latched: a read shows the pins at its address phase
    always_comb begin
        status = 8'h00;
        status[ppm_pkg::ST_FAULT]  = printer_fault_n;
        status[ppm_pkg::ST_SELECT] = printer_selected_in;
        status[ppm_pkg::ST_PAPER]  = paper_out_in;
        status[ppm_pkg::ST_ACK]    = printer_acknowledge_n;
        status[ppm_pkg::ST_BUSY]   = ~printer_busy_in;
    end

    // Next values for bus state; read data formed in address phase
    always_comb begin
        nxt_wr_pend = take && hwrite;
        nxt_addr    = take ? haddr[7:0] : addr_ff;
        nxt_rdata   = rdata_ff;
        nxt_mode    = mode_ff;
        if (take && !hwrite) begin
            case (haddr[7:0])
                ppm_pkg::DATA_OFS: begin
                    // Sensed lines when turned round, else latch
                    nxt_rdata = rd_word(ctrl_q[ppm_pkg::CTL_DIR] ?
                                        port_data_in_in : data_q);
                end
                ppm_pkg::STATUS_OFS: nxt_rdata = rd_word(status);
                ppm_pkg::CTRL_OFS:   nxt_rdata = rd_word(ctrl_q);
                ppm_pkg::MODE_OFS:   nxt_rdata = rd_word({6'h00, mode_ff});
                default:             nxt_rdata = 32'h0; // Unmapped reads zero
            endcase
        end
        if (wr_pend_ff && addr_ff == ppm_pkg::MODE_OFS) begin
            nxt_mode = hwdata[1:0];
        end
    end

    // Bus state registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            rdata_ff   <= 32'h0;
            mode_ff    <= ppm_pkg::MODE_RST;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff    <= nxt_addr;
            rdata_ff   <= nxt_rdata;
            mode_ff    <= nxt_mode;
        end
    end

    assign wr_ctrl   = wr_pend_ff && (addr_ff == ppm_pkg::CTRL_OFS);
    assign wr_data   = wr_pend_ff && (addr_ff == ppm_pkg::DATA_OFS);
    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1; // Never waits
    assign hresp     = 1'b0; // Always OKAY

    ////////////////////////////////////////////////////////////////////
    // Control and data registers
    ppm_reg8 #(.RST_VAL(ppm_pkg::CTRL_RST)) u_ctrl (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .wr_in      (wr_ctrl),
        .d_in       (hwdata[7:0]),
        .q_out      (ctrl_q)
    );

    ppm_reg8 #(.RST_VAL(ppm_pkg::DATA_RST)) u_data (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .wr_in      (wr_data),
        .d_in       (hwdata[7:0]),
        .q_out      (data_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin mapping; outside standard mode the four control pins idle inactive and
    // other logic takes them over
    assign std_mode_out = (mode_ff == ppm_pkg::MODE_STD);

    always_comb begin
        if (std_mode_out) begin
            // Init follows bit 2 unchanged; the other three are inverted
            printer_initialise_n = ctrl_q[ppm_pkg::CTL_INIT];
            printer_select_out_n = ~ctrl_q[ppm_pkg::CTL_SELIN];
            data_latch_pulse_n   = ~ctrl_q[ppm_pkg::CTL_STROBE];
            auto_line_feed_n     = ~ctrl_q[ppm_pkg::CTL_ALF];
        end else begin
            // Inactive levels while reassigned
            printer_initialise_n = 1'b1;
            printer_select_out_n = 1'b1;
            data_latch_pulse_n   = 1'b1;
            auto_line_feed_n     = 1'b1;
        end
    end

    // Data latch drives lines unless turned round for input
    assign port_data_out_out  = data_q;
    assign port_data_oe_n_out = ctrl_q[ppm_pkg::CTL_DIR];

    ////////////////////////////////////////////////////////////////////
    // Assertions
    // Init, select and line feed levels are checked every cycle in standard mode, strobe
    // after a control write that sets bit 0; status bits one edge after the address phase, once hrdata has been loaded
    a_init_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        std_mode_out |-> printer_initialise_n == ctrl_q[2])
        else $error("init output mismatch");
    a_select_inv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        std_mode_out |-> printer_select_out_n != ctrl_q[3])
        else $error("select output mismatch");
    a_status_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04 |=> hrdata[4] == $past(printer_selected_in))
        else $error("status select bit wrong");
    a_status_paper: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04 |=> hrdata[5] == $past(paper_out_in))
        else $error("status paper bit wrong");
    a_status_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04 |=> hrdata[7] != $past(printer_busy_in))
        else $error("status busy bit wrong");
    a_status_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04 |=> hrdata[6] == $past(printer_acknowledge_n))
        else $error("status ack bit wrong");
    a_data_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_data |=> port_data_out_out == $past(hwdata[7:0]))
        else $error("data latch not loaded");
    a_strobe_inv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_ctrl && std_mode_out && hwdata[0] |=> !data_latch_pulse_n)
        else $error("strobe not asserted");
    a_alf_inv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        std_mode_out |-> auto_line_feed_n != ctrl_q[1])
        else $error("line feed output mismatch");
    a_status_fault: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04 |=> hrdata[3] == $past(printer_fault_n))
        else $error("status fault bit wrong");
    a_mode_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !std_mode_out |-> data_latch_pulse_n && printer_select_out_n &&
                          printer_initialise_n && auto_line_feed_n)
        else $error("pins not idle outside standard mode");
    a_dir_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        port_data_oe_n_out == ctrl_q[ppm_pkg::CTL_DIR])
        else $error("data line enable does not follow direction bit");
    a_dir_sense: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == ppm_pkg::DATA_OFS && ctrl_q[ppm_pkg::CTL_DIR]
        |=> hrdata[7:0] == $past(port_data_in_in))
        else $error("sensed data lines not returned");

    c_strobe: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        !data_latch_pulse_n ##1 data_latch_pulse_n);
    c_status_rd: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == 8'h04);
    c_turnround: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        port_data_oe_n_out);
    // Pins handed to other logic, and a status read during acknowledge
    c_mode_ext: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        !std_mode_out);
    c_ack_read: cover property (@(posedge sys_clk_in) disable iff (rst_in)
        take && !hwrite && haddr[7:0] == ppm_pkg::STATUS_OFS && !printer_acknowledge_n);
endmodule : ppm_port

// File: ppm_printer.sv
// Purpose: Printer model on the far side of the port pins
// Assumes: Levels synchronous to sys_clk_in
// Notes:   Busy while strobe is low, then acknowledge for 8 cycles
module ppm_printer (
    input  wire logic       sys_clk_in, // Clock
    input  wire logic       strobe_n_in, // Data latch pulse
    input  wire logic [7:0] lines_in,    // Data line levels
    output logic            busy_out,    // Cannot take data
    output logic            ack_n_out,   // Ready again, low
    output logic      [7:0] byte_out     // Last byte taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       strobe_q_ff = 1'b1; // Strobe one cycle ago
    logic [3:0] ack_cnt_ff  = 4'h0; // Acknowledge cycles left
    ////////////////////////////////////////////////////////////////
    // Latch on falling strobe, acknowledge after rising strobe
    always_ff @(posedge sys_clk_in) begin
        strobe_q_ff <= strobe_n_in;
        if (strobe_q_ff && !strobe_n_in) begin
            byte_out <= lines_in; // Byte taken on fall
        end
        if (!strobe_q_ff && strobe_n_in) begin
            ack_cnt_ff <= 4'h8;
        end else if (ack_cnt_ff != 4'h0) begin
            ack_cnt_ff <= ack_cnt_ff - 4'h1;
        end
    end
    assign busy_out  = !strobe_n_in;        // Busy while strobed
    assign ack_n_out = (ack_cnt_ff == 4'h0); // Low pulse after data
endmodule : ppm_printer

// File: printer_port_pin_mapping_tb.sv
// Purpose: Self-checking bench for the printer port pins
// Assumes: Zero wait-state slave, status sampled at address phase
// Notes:   Printer drives 8'h5a whenever the block releases the lines
module printer_port_pin_mapping_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1;        // Clock and reset
    logic        hsel = 1'b0, hwrite = 1'b0;   // AHB controls
    logic [31:0] haddr = '0, hwdata = '0, rd;  // Address, data
    logic [1:0]  htrans = 2'h0;                // Transfer type
    logic [2:0]  hsize = 3'h2;                 // Word size
    logic [31:0] hrdata;                       // Read data
    logic        hreadyout, hresp, std_mode;   // Slave outputs
    logic        init_n, sel_n, stb_n, alf_n;  // Handshake pins
    logic        sel = 1'b0, paper = 1'b0;     // Printer status
    logic        fault_n = 1'b1, busy, ack_n;  // Printer status
    logic [7:0]  dout, lines, pbyte;           // Data lines
    logic        oe_n;                         // Low while driving
    int          failures = 0, checked = 0;    // Counters
    // Wire level from both ends
    assign lines = oe_n ? 8'h5a : dout;
    initial forever #20 clk = ~clk;
    ppm_port u_ppm_port (.sys_clk_in(clk), .rst_in(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .printer_initialise_n(init_n), .printer_select_out_n(sel_n),
        .data_latch_pulse_n(stb_n), .auto_line_feed_n(alf_n),
        .printer_selected_in(sel), .paper_out_in(paper), .printer_busy_in(busy),
        .printer_acknowledge_n(ack_n), .printer_fault_n(fault_n),
        .port_data_in_in(lines), .port_data_out_out(dout),
        .port_data_oe_n_out(oe_n), .std_mode_out(std_mode));
    ppm_printer u_ppm_printer (.sys_clk_in(clk), .strobe_n_in(stb_n),
        .lines_in(lines), .busy_out(busy), .ack_n_out(ack_n), .byte_out(pbyte));
    ////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin failures++; give_verdict(); end
    endtask : wait_rdy
    // One single transfer; read data lands in rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        wait_rdy();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", hresp, 32'h0);
    endtask : bus
    // Let a write reach the pins
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask : settle
    function automatic logic [3:0] pins_exp(input logic [7:0] c);
        return {c[2], ~c[3], ~c[0], ~c[1]};
    endfunction : pins_exp
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_ctrl;
        for (int i = 0; i < 16; i++) begin
            bus(ppm_pkg::CTRL_OFS, 1'b1, i); settle();
            chk("pins", {init_n, sel_n, stb_n, alf_n}, pins_exp(i[7:0]));
        end
        bus(ppm_pkg::CTRL_OFS, 1'b0, 0);
        chk("ctrl rd", rd, 32'h0f);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h04);
        repeat (12) @(posedge clk); // Let the printer's acknowledge end
    endtask : t_ctrl
    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk); {sel, paper, fault_n} <= i[2:0];
            bus(ppm_pkg::STATUS_OFS, 1'b0, 0);
            chk("status", rd, {24'h0, 2'b11, i[1], i[2], i[0], 3'h0});
        end
    endtask : t_status
    task automatic t_strobe;
        bus(ppm_pkg::DATA_OFS, 1'b1, 32'ha5);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h05); settle();
        bus(ppm_pkg::STATUS_OFS, 1'b0, 0);
        chk("busy", rd[7:6], 2'b01);
        chk("byte", pbyte, 8'ha5);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h04); settle();
        bus(ppm_pkg::STATUS_OFS, 1'b0, 0);
        chk("ack", rd[7:6], 2'b10);
        repeat (12) @(posedge clk);
        bus(ppm_pkg::STATUS_OFS, 1'b0, 0);
        chk("idle", rd[7:6], 2'b11);
    endtask : t_strobe
    task automatic t_dir;
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h24); settle();
        chk("oe_n", oe_n, 1'b1);
        bus(ppm_pkg::DATA_OFS, 1'b0, 0);
        chk("sensed", rd, 32'h5a);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h04); settle();
        chk("drive", {oe_n, dout}, 9'h0a5);
    endtask : t_dir
    task automatic t_mode;
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h0b); settle();
        chk("std", {std_mode, init_n, sel_n, stb_n, alf_n}, 5'h10);
        bus(ppm_pkg::MODE_OFS, 1'b1, 32'h1); settle();
        chk("ext", {std_mode, init_n, sel_n, stb_n, alf_n}, 5'h0f);
        bus(ppm_pkg::MODE_OFS, 1'b0, 0);
        chk("mode rd", rd, 32'h1);
        bus(ppm_pkg::MODE_OFS, 1'b1, 32'h0); settle();
        chk("back", {std_mode, init_n, sel_n, stb_n, alf_n}, 5'h10);
        bus(8'h10, 1'b0, 0);
        chk("unmapped", rd, 32'h0);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h04);
    endtask : t_mode
    // Reset in mid-run returns every register and pin to idle
    task automatic t_reset;
        bus(ppm_pkg::MODE_OFS, 1'b1, 32'h2);
        bus(ppm_pkg::CTRL_OFS, 1'b1, 32'h2f);
        bus(ppm_pkg::DATA_OFS, 1'b1, 32'h3c);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("rerun", {init_n, sel_n, stb_n, alf_n, oe_n, dout}, 13'h1e00);
        bus(ppm_pkg::CTRL_OFS, 1'b0, 0);
        chk("ctrl rst", rd, 32'h04);
        bus(ppm_pkg::MODE_OFS, 1'b0, 0);
        chk("mode rst", rd, 32'h0);
    endtask : t_reset
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("reset", {init_n, sel_n, stb_n, alf_n, oe_n, dout}, 13'h1e00);
        @(posedge clk);
        t_ctrl(); t_status(); t_strobe(); t_dir(); t_mode(); t_reset();
        give_verdict();
    end
endmodule : printer_port_pin_mapping_tb
